// ==== wcs_pkg.sv ====
// constants, types and helpers for the wake-up and cyclic sense controller
// Functional notes
// - a Normal mode request (mode value 0) while in Stop wakes the die.
// - a wake-up by Normal mode request sets no wake source flag.
// - core low voltage or external reset in Stop wakes into Reset mode.
// - that reset-caused wake records the low-voltage or external-reset flag.
// - in Sleep, main supply below power-on threshold enters Power On mode.
// - wake control bits 7-6 select cyclic sense: off, output 1, 2, both.
// - cyclic sense without input enables still pulses the output, detects none.
// - wake control bits 5-0 enable input wake-ups, all reset to one.
// - forced wake-up runs alongside every cyclic sense selection.
// - timing bits 7-4 nonzero force a wake every multiplier times period.
// - multiplier codes decode 0 off, then 1x, 2x, 4x, 8x ... 1024x.
// - multiplier codes 1100 and above act as 1024x.
// - period codes 1010 to 1111 act as 1000 ms.
// - source register: bit 7 forced, bit 6 LIN, bits 5-0 inputs.
// - reading the source register clears returned flags; writes do nothing.
// - a new Stop command needs the source register read after a wake.
// - cyclic sense off: any enabled input change wakes a low-power die.
// - cyclic sense on: change seen only between successive sense samples.
// - simultaneous forced and input wake reports only the forced wake.
// - Stop wake raises link interrupt and enters Normal; Sleep wake resets.
package wcs_pkg;

  localparam logic [7:0] WAKE_CONTROL_ADDR  = 8'h12;
  localparam logic [7:0] WAKE_TIMING_ADDR   = 8'h13;
  localparam logic [7:0] WAKE_SOURCE_ADDR   = 8'h14;
  localparam logic [7:0] RESET_STATUS_ADDR  = 8'h15;

  localparam logic [7:0] WAKE_CONTROL_RESET = 8'h3f;
  localparam logic [7:0] WAKE_TIMING_RESET  = 8'h00;

  localparam int          RESET_LVR_BIT     = 1;
  localparam int          RESET_EXR_BIT     = 4;

  localparam int          CNT_W             = 20;
  localparam int          BASE_CLK_HZ       = 100_000_000;
  localparam int          MS_PER_S          = 1000;
  localparam int          CYCLES_PER_MS     = BASE_CLK_HZ / MS_PER_S;
  // high-side on time before inputs are sampled
  localparam int          SENSE_ON_NS       = 80;
  localparam int          CLK_PERIOD_NS     = 10;
  localparam logic [3:0]  SENSE_ON_CYCLES   =
    4'((SENSE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    WCS_NORMAL = 2'b00,
    WCS_STOP   = 2'b01,
    WCS_SLEEP  = 2'b11,
    WCS_RESET  = 2'b10
  } wcs_mode_type;

  typedef struct packed {
    logic [1:0] cyclic_sense_select;
    logic [5:0] input_wake_enable;
  } wcs_control_type;

  typedef struct packed {
    logic [3:0] forced_wake_multiplier;
    logic [3:0] cyclic_sense_period;
  } wcs_timing_type;

  typedef struct packed {
    logic       forced_wake_flag;
    logic       lin_wake_flag;
    logic [5:0] input_wake_flag;
  } wcs_source_type;

  // cyclic sense period in ms
  function automatic logic [CNT_W-1:0] wcs_period_ms(input logic [3:0] code);
    logic [CNT_W-1:0] ms;
    ms = 20'h003e8;
    unique case (code)
      4'h0: ms = 20'h00001;
      4'h1: ms = 20'h00002;
      4'h2: ms = 20'h00005;
      4'h3: ms = 20'h0000a;
      4'h4: ms = 20'h00014;
      4'h5: ms = 20'h00032;
      4'h6: ms = 20'h00064;
      4'h7: ms = 20'h000c8;
      4'h8: ms = 20'h001f4;
      default: ms = 20'h003e8;
    endcase
    return ms;
  endfunction : wcs_period_ms

  // forced wake multiplier, in cyclic sense periods
  function automatic logic [CNT_W-1:0] wcs_multiplier(input logic [3:0] code);
    logic [CNT_W-1:0] m;
    m = 20'h00400;
    if (code < 4'hb) begin
      m = CNT_W'(20'h00001 << (code - 4'h1));
    end else begin
      m = 20'h00400;
    end
    return m;
  endfunction : wcs_multiplier

endpackage : wcs_pkg

// ==== wcs_tick_counter.sv ====
// free counter that pulses once every limit enabled cycles
`timescale 1ns/1ps
module wcs_tick_counter (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    restart,
  input  wire logic                    enable,
  input  wire logic [wcs_pkg::CNT_W-1:0] limit,
  output logic                         tick
);

  logic [wcs_pkg::CNT_W-1:0] count;
  logic [wcs_pkg::CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    tick       = 1'b0;
    if (restart) begin
      next_count = '0;
    end else if (enable) begin
      if (count + 1'b1 >= limit) begin
        next_count = '0;
        tick       = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : wcs_tick_counter

// ==== wcs_wake_control.sv ====
// wake-up sources, cyclic sense and forced wake-up of the low-power modes
`timescale 1ns/1ps
module wcs_wake_control #(
  parameter int TICKS_PER_MS = wcs_pkg::CYCLES_PER_MS
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  mode_normal_req,
  input  wire logic                  mode_stop_req,
  input  wire logic                  mode_sleep_req,
  input  wire logic                  reset_done,
  input  wire logic [5:0]            wake_pin,
  input  wire logic                  lin_wake,
  input  wire logic                  core_low_voltage,
  input  wire logic                  external_reset,
  input  wire logic                  supply_below_por,
  output logic                       high_side_output_1,
  output logic                       high_side_output_2,
  output logic                       die_link_interrupt,
  output logic                       reset_entry,
  output logic                       power_on_entry,
  output logic                       stop_blocked,
  output wcs_pkg::wcs_mode_type      mode
);

  // two-stage synchronisers for the pin inputs
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic [5:0] wake_pin_s;
  logic       low_volt_s;
  logic       ext_reset_s;
  logic       below_por_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {supply_below_por, external_reset, core_low_voltage,
                   wake_pin};
      pin_sync <= pin_meta;
    end
  end

  assign wake_pin_s  = pin_sync[5:0];
  assign low_volt_s  = pin_sync[6];
  assign ext_reset_s = pin_sync[7];
  assign below_por_s = pin_sync[8];

  // register and mode state
  wcs_pkg::wcs_control_type ctrl;
  wcs_pkg::wcs_control_type next_ctrl;
  wcs_pkg::wcs_timing_type  timing;
  wcs_pkg::wcs_timing_type  next_timing;
  wcs_pkg::wcs_source_type  source;
  wcs_pkg::wcs_source_type  next_source;
  logic                     lvr_flag;
  logic                     next_lvr_flag;
  logic                     exr_flag;
  logic                     next_exr_flag;
  logic [7:0]               next_reg_rdata;
  wcs_pkg::wcs_mode_type    next_mode;
  logic                     wake_unread;
  logic                     next_wake_unread;
  logic                     next_irq;
  logic                     next_reset_entry;
  logic                     next_power_on_entry;

  // cyclic sense state
  logic [3:0]               sense_cnt;
  logic [3:0]               next_sense_cnt;
  logic [5:0]               last_sample;
  logic [5:0]               next_last_sample;
  logic                     have_sample;
  logic                     next_have_sample;
  logic                     hs_on;
  logic                     next_hs_on;

  logic                     low_power;
  logic                     ms_tick;
  logic                     sense_tick;
  logic                     forced_tick;
  logic                     forced_on;
  logic                     sample_now;
  logic [5:0]               input_change;
  logic                     any_wake;
  logic                     read_source;
  logic                     read_reset;

  assign low_power   = (mode == wcs_pkg::WCS_STOP) ||
                       (mode == wcs_pkg::WCS_SLEEP);
  assign forced_on   = timing.forced_wake_multiplier != 4'h0;
  assign read_source = reg_rd && reg_addr == wcs_pkg::WAKE_SOURCE_ADDR;
  assign read_reset  = reg_rd && reg_addr == wcs_pkg::RESET_STATUS_ADDR;

  // period generation from the base clock
  wcs_tick_counter u_ms_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (!low_power),
    .enable  (1'b1),
    .limit   (wcs_pkg::CNT_W'(TICKS_PER_MS)),
    .tick    (ms_tick)
  );

  wcs_tick_counter u_sense_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (!low_power),
    .enable  (ms_tick),
    .limit   (wcs_pkg::wcs_period_ms(timing.cyclic_sense_period)),
    .tick    (sense_tick)
  );

  wcs_tick_counter u_forced_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (!low_power || !forced_on),
    .enable  (sense_tick),
    .limit   (wcs_pkg::wcs_multiplier(timing.forced_wake_multiplier)),
    .tick    (forced_tick)
  );

  // cyclic sense switching and input change detection
  always_comb begin
    next_sense_cnt   = sense_cnt;
    next_last_sample = last_sample;
    next_have_sample = have_sample;
    next_hs_on       = 1'b0;
    sample_now       = 1'b0;
    input_change     = '0;
    if (!low_power) begin
      next_sense_cnt   = '0;
      next_have_sample = 1'b0;
      next_last_sample = wake_pin_s;
    end else if (ctrl.cyclic_sense_select == 2'b00) begin
      // continuous watch against the level sampled in the previous cycle
      input_change     = (wake_pin_s ^ last_sample) &
                         ctrl.input_wake_enable;
      next_last_sample = wake_pin_s;
    end else begin
      if (sense_tick) begin
        next_sense_cnt = wcs_pkg::SENSE_ON_CYCLES;
        next_hs_on     = 1'b1;
      end else if (sense_cnt != 4'h0) begin
        next_sense_cnt = sense_cnt - 4'h1;
        next_hs_on     = sense_cnt != 4'h1;
        sample_now     = sense_cnt == 4'h1;
      end
      if (sample_now) begin
        next_last_sample = wake_pin_s;
        next_have_sample = 1'b1;
        if (have_sample) begin
          input_change = (wake_pin_s ^ last_sample) &
                         ctrl.input_wake_enable;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_cnt   <= '0;
      last_sample <= '0;
      have_sample <= 1'b0;
      hs_on       <= 1'b0;
    end else begin
      sense_cnt   <= next_sense_cnt;
      last_sample <= next_last_sample;
      have_sample <= next_have_sample;
      hs_on       <= next_hs_on;
    end
  end

  assign high_side_output_1 = hs_on && ctrl.cyclic_sense_select[0];
  assign high_side_output_2 = hs_on && ctrl.cyclic_sense_select[1];

  // mode sequencing, wake sources and register file
  always_comb begin
    next_mode           = mode;
    next_ctrl           = ctrl;
    next_timing         = timing;
    next_source         = source;
    next_lvr_flag       = lvr_flag;
    next_exr_flag       = exr_flag;
    next_wake_unread    = wake_unread;
    next_irq            = 1'b0;
    next_reset_entry    = 1'b0;
    next_power_on_entry = 1'b0;
    next_reg_rdata      = reg_rdata;
    any_wake            = low_power &&
                          (forced_tick || lin_wake || input_change != '0);

    if (reg_rd) begin
      unique case (reg_addr)
        wcs_pkg::WAKE_CONTROL_ADDR: next_reg_rdata = ctrl;
        wcs_pkg::WAKE_TIMING_ADDR:  next_reg_rdata = timing;
        wcs_pkg::WAKE_SOURCE_ADDR:  next_reg_rdata = source;
        wcs_pkg::RESET_STATUS_ADDR: begin
          next_reg_rdata = '0;
          next_reg_rdata[wcs_pkg::RESET_LVR_BIT] = lvr_flag;
          next_reg_rdata[wcs_pkg::RESET_EXR_BIT] = exr_flag;
        end
        default: next_reg_rdata = 8'h00;
      endcase
    end
    if (reg_wr && reg_addr == wcs_pkg::WAKE_CONTROL_ADDR) begin
      next_ctrl = reg_wdata;
    end
    if (reg_wr && reg_addr == wcs_pkg::WAKE_TIMING_ADDR) begin
      next_timing = reg_wdata;
    end

    // read clears only what it returned; a new event still lands
    if (read_source) begin
      next_source      = '0;
      next_wake_unread = 1'b0;
    end
    if (read_reset) begin
      next_lvr_flag = 1'b0;
      next_exr_flag = 1'b0;
    end

    unique case (mode)
      wcs_pkg::WCS_NORMAL: begin
        if (mode_stop_req && !wake_unread) begin
          next_mode = wcs_pkg::WCS_STOP;
        end else if (mode_sleep_req && !wake_unread) begin
          next_mode = wcs_pkg::WCS_SLEEP;
        end
      end
      wcs_pkg::WCS_STOP: begin
        if (low_volt_s || ext_reset_s) begin
          next_mode        = wcs_pkg::WCS_RESET;
          next_reset_entry = 1'b1;
          if (low_volt_s) begin
            next_lvr_flag = 1'b1;
          end
          if (ext_reset_s) begin
            next_exr_flag = 1'b1;
          end
        end else if (mode_normal_req) begin
          next_mode = wcs_pkg::WCS_NORMAL;
        end else if (any_wake) begin
          next_mode = wcs_pkg::WCS_NORMAL;
          next_irq  = 1'b1;
        end
      end
      wcs_pkg::WCS_SLEEP: begin
        if (below_por_s) begin
          next_mode           = wcs_pkg::WCS_RESET;
          next_power_on_entry = 1'b1;
        end else if (any_wake) begin
          next_mode        = wcs_pkg::WCS_RESET;
          next_reset_entry = 1'b1;
        end
      end
      wcs_pkg::WCS_RESET: begin
        next_ctrl   = wcs_pkg::WAKE_CONTROL_RESET;
        next_timing = wcs_pkg::WAKE_TIMING_RESET;
        if (reset_done) begin
          next_mode = wcs_pkg::WCS_NORMAL;
        end
      end
    endcase

    if (any_wake && !((mode == wcs_pkg::WCS_STOP) &&
        (low_volt_s || ext_reset_s || mode_normal_req)) &&
        !((mode == wcs_pkg::WCS_SLEEP) && below_por_s)) begin
      next_wake_unread = 1'b1;
      if (forced_tick) begin
        next_source.forced_wake_flag = 1'b1;
      end else begin
        next_source.lin_wake_flag   = next_source.lin_wake_flag | lin_wake;
        next_source.input_wake_flag = next_source.input_wake_flag |
                                      input_change;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode           <= wcs_pkg::WCS_NORMAL;
      ctrl           <= wcs_pkg::WAKE_CONTROL_RESET;
      timing         <= wcs_pkg::WAKE_TIMING_RESET;
      source         <= '0;
      lvr_flag       <= 1'b0;
      exr_flag       <= 1'b0;
      wake_unread    <= 1'b0;
      die_link_interrupt <= 1'b0;
      reset_entry    <= 1'b0;
      power_on_entry <= 1'b0;
      reg_rdata      <= '0;
    end else begin
      mode           <= next_mode;
      ctrl           <= next_ctrl;
      timing         <= next_timing;
      source         <= next_source;
      lvr_flag       <= next_lvr_flag;
      exr_flag       <= next_exr_flag;
      wake_unread    <= next_wake_unread;
      die_link_interrupt <= next_irq;
      reset_entry    <= next_reset_entry;
      power_on_entry <= next_power_on_entry;
      reg_rdata      <= next_reg_rdata;
    end
  end

  assign stop_blocked = wake_unread;

endmodule : wcs_wake_control

// ==== wcs_wake_control_props.sv ====
// concurrent checks on the ports of the wake-up controller
`timescale 1ns/1ps
module wcs_wake_control_props (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_rd,
  input wire logic             mode_normal_req,
  input wire logic             mode_stop_req,
  input wire logic             lin_wake,
  input wire logic             core_low_voltage,
  input wire logic             external_reset,
  input wire logic             supply_below_por,
  input wire logic             high_side_output_1,
  input wire logic             high_side_output_2,
  input wire logic             die_link_interrupt,
  input wire logic             reset_entry,
  input wire logic             power_on_entry,
  input wire logic             stop_blocked,
  input wcs_pkg::wcs_mode_type mode
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_normal_wake;
    (!core_low_voltage && !external_reset)[*3] ##0
      (mode == wcs_pkg::WCS_STOP && mode_normal_req)
      |=> mode == wcs_pkg::WCS_NORMAL && !die_link_interrupt;
  endproperty
  a_normal_wake: assert property (p_normal_wake)
    else $error("normal request wake misbehaved");
  property p_int;
    die_link_interrupt |-> mode == wcs_pkg::WCS_NORMAL &&
      $past(mode) == wcs_pkg::WCS_STOP;
  endproperty
  a_int: assert property (p_int)
    else $error("link interrupt without stop wake");
  property p_blocked;
    stop_blocked && mode_stop_req && mode == wcs_pkg::WCS_NORMAL
      |=> mode == wcs_pkg::WCS_NORMAL;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("stop taken before source read");
  property p_unblock;
    reg_rd && reg_addr == 8'h14 && mode == wcs_pkg::WCS_NORMAL
      |=> !stop_blocked;
  endproperty
  a_unblock: assert property (p_unblock)
    else $error("source read left stop blocked");
  property p_rst_wake;
    mode == wcs_pkg::WCS_STOP && (core_low_voltage || external_reset)
      |-> ##[1:4] (mode == wcs_pkg::WCS_RESET && reset_entry);
  endproperty
  a_rst_wake: assert property (p_rst_wake)
    else $error("stop did not wake into reset");
  property p_por;
    $rose(supply_below_por) && mode == wcs_pkg::WCS_SLEEP
      |-> ##[1:4] power_on_entry;
  endproperty
  a_por: assert property (p_por)
    else $error("supply loss in sleep not seen");
  property p_sleep_wake;
    (!supply_below_por)[*3] ##0 (mode == wcs_pkg::WCS_SLEEP && lin_wake)
      |=> mode == wcs_pkg::WCS_RESET && reset_entry;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep wake did not enter reset");
  property p_hs_quiet;
    mode == wcs_pkg::WCS_NORMAL && $past(mode) == wcs_pkg::WCS_NORMAL
      |-> !high_side_output_1 && !high_side_output_2;
  endproperty
  a_hs_quiet: assert property (p_hs_quiet)
    else $error("high side switched in normal mode");
  property p_hs_window;
    $fell(high_side_output_1) && mode == wcs_pkg::WCS_STOP
      |-> $past(high_side_output_1, 8) && !$past(high_side_output_1, 9);
  endproperty
  a_hs_window: assert property (p_hs_window)
    else $error("sense window length wrong");
endmodule : wcs_wake_control_props

bind wcs_wake_control wcs_wake_control_props u_props (
  .clk, .sys_rst, .reg_addr, .reg_rd, .mode_normal_req, .mode_stop_req,
  .lin_wake, .core_low_voltage, .external_reset, .supply_below_por,
  .high_side_output_1, .high_side_output_2, .die_link_interrupt,
  .reset_entry, .power_on_entry, .stop_blocked, .mode
);

// ==== wcs_mcu_model.sv ====
// controller model: register access and mode requests over the die link
`timescale 1ns/1ps
module wcs_mcu_model (
  input  wire logic       clk,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  output logic            mode_normal_req,
  output logic            mode_stop_req,
  output logic            mode_sleep_req
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    mode_normal_req = 1'b0;
    mode_stop_req = 1'b0;
    mode_sleep_req = 1'b0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
    reg_addr = ~a;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask : read_reg

  task automatic request_mode(input wcs_pkg::wcs_mode_type m);
    // settle time after any source read before a mode write
    repeat (3) @(negedge clk);
    mode_normal_req = (m == wcs_pkg::WCS_NORMAL);
    mode_stop_req = (m == wcs_pkg::WCS_STOP);
    mode_sleep_req = (m == wcs_pkg::WCS_SLEEP);
    @(negedge clk);
    mode_normal_req = 1'b0;
    mode_stop_req = 1'b0;
    mode_sleep_req = 1'b0;
  endtask : request_mode
endmodule : wcs_mcu_model

// ==== wcs_wake_control_tb.sv ====
// self-checking bench for the wake-up and cyclic sense controller
`timescale 1ns/1ps
module wcs_wake_control_tb;
  localparam int TPM = 10;
  logic       clk, sys_rst, reset_done, lin_wake;
  logic       core_low_voltage, external_reset, supply_below_por;
  logic       reg_wr, reg_rd, mode_normal_req, mode_stop_req;
  logic       mode_sleep_req, high_side_output_1, high_side_output_2;
  logic       die_link_interrupt, reset_entry, power_on_entry, stop_blocked;
  logic [5:0] wake_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wcs_pkg::wcs_mode_type mode;
  int         num_errors = 0;
  int         checked = 0;
  int         n;
  // forced setups keep the sense period within the forced period
  logic [7:0] tim [12] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h80,
                           8'h90, 8'ha0, 8'hf0, 8'h12, 8'h17, 8'h1c};
  int         cyc [12] = '{10, 20, 40, 80, 160, 1280,
                           2560, 5120, 10240, 50, 2000, 10000};

  wcs_wake_control #(.TICKS_PER_MS(TPM)) u_dut (
    .clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .mode_normal_req, .mode_stop_req, .mode_sleep_req, .reset_done,
    .wake_pin, .lin_wake, .core_low_voltage, .external_reset,
    .supply_below_por, .high_side_output_1, .high_side_output_2,
    .die_link_interrupt, .reset_entry, .power_on_entry, .stop_blocked,
    .mode
  );
  wcs_mcu_model u_mcu (
    .clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .mode_normal_req, .mode_stop_req, .mode_sleep_req
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_mcu.read_reg(a, v);
    check(v, exp);
  endtask : rd_chk

  task automatic chk_mode(input wcs_pkg::wcs_mode_type m);
    check({6'h00, mode}, {6'h00, m});
  endtask : chk_mode

  task automatic go(input wcs_pkg::wcs_mode_type m);
    u_mcu.request_mode(m);
  endtask : go

  task automatic wait_mode(input wcs_pkg::wcs_mode_type m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (mode !== m) begin
      num_errors++;
      $display("ERROR %0t: mode wait timed out", $time);
      give_verdict();
    end
  endtask : wait_mode

  task automatic wait_hs(input logic lvl);
    int k;
    k = 0;
    while (high_side_output_1 !== lvl && k < 40) begin
      @(negedge clk);
      k++;
    end
    check({7'h00, high_side_output_1}, {7'h00, lvl});
  endtask : wait_hs

  initial begin
    sys_rst = 1'b1;
    reset_done = 1'b0;
    lin_wake = 1'b0;
    core_low_voltage = 1'b0;
    external_reset = 1'b0;
    supply_below_por = 1'b0;
    wake_pin = 6'h00;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rd_chk(8'h12, 8'h3f);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h20, 8'h00);
    u_mcu.write_reg(8'h14, 8'hff);
    rd_chk(8'h14, 8'h00);
    u_mcu.write_reg(8'h12, 8'h81);
    rd_chk(8'h12, 8'h81);
    go(wcs_pkg::WCS_STOP);
    chk_mode(wcs_pkg::WCS_STOP);
    go(wcs_pkg::WCS_NORMAL);
    check({7'h00, die_link_interrupt}, 8'h00);
    wait_mode(wcs_pkg::WCS_NORMAL, 4);
    rd_chk(8'h14, 8'h00);
    // direct input wake with sense off, one input enabled
    u_mcu.write_reg(8'h12, 8'h01);
    go(wcs_pkg::WCS_STOP);
    wake_pin = 6'h02;
    repeat (10) @(negedge clk);
    chk_mode(wcs_pkg::WCS_STOP);
    wake_pin = 6'h03;
    wait_mode(wcs_pkg::WCS_NORMAL, 8);
    check({7'h00, die_link_interrupt}, 8'h01);
    go(wcs_pkg::WCS_STOP);
    chk_mode(wcs_pkg::WCS_NORMAL);
    check({7'h00, stop_blocked}, 8'h01);
    u_mcu.write_reg(8'h14, 8'h00);
    rd_chk(8'h14, 8'h01);
    rd_chk(8'h14, 8'h00);
    // reset-caused wakes out of stop, low voltage then external reset
    for (int i = 0; i < 2; i++) begin
      go(wcs_pkg::WCS_STOP);
      chk_mode(wcs_pkg::WCS_STOP);
      core_low_voltage = (i == 0);
      external_reset = (i == 1);
      wait_mode(wcs_pkg::WCS_RESET, 8);
      check({7'h00, reset_entry}, 8'h01);
      core_low_voltage = 1'b0;
      external_reset = 1'b0;
      rd_chk(8'h15, (i == 0) ? 8'h02 : 8'h10);
      rd_chk(8'h12, 8'h3f);
      reset_done = 1'b1;
      wait_mode(wcs_pkg::WCS_NORMAL, 8);
      reset_done = 1'b0;
      rd_chk(8'h14, 8'h00);
    end
    go(wcs_pkg::WCS_SLEEP);
    lin_wake = 1'b1;
    @(negedge clk);
    lin_wake = 1'b0;
    chk_mode(wcs_pkg::WCS_RESET);
    rd_chk(8'h14, 8'h40);
    reset_done = 1'b1;
    wait_mode(wcs_pkg::WCS_NORMAL, 8);
    reset_done = 1'b0;
    go(wcs_pkg::WCS_SLEEP);
    supply_below_por = 1'b1;
    n = 0;
    while (!power_on_entry && n < 8) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, power_on_entry}, 8'h01);
    sys_rst = 1'b1;
    supply_below_por = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    // each sense select 1 to 3 with no input enabled: outputs pulse, no wake
    for (int s = 1; s < 4; s++) begin
      u_mcu.write_reg(8'h12, {s[1:0], 6'h00});
      go(wcs_pkg::WCS_STOP);
      n = 0;
      while (!(high_side_output_1 | high_side_output_2) && n < 40) begin
        @(negedge clk);
        n++;
      end
      check({6'h00, high_side_output_2, high_side_output_1},
            {6'h00, s[1:0]});
      wake_pin = ~wake_pin;
      repeat (40) @(negedge clk);
      chk_mode(wcs_pkg::WCS_STOP);
      go(wcs_pkg::WCS_NORMAL);
      wait_mode(wcs_pkg::WCS_NORMAL, 4);
      rd_chk(8'h14, 8'h00);
    end
    // sampled detection: change seen only at the next sense event
    u_mcu.write_reg(8'h12, 8'h41);
    go(wcs_pkg::WCS_STOP);
    wait_hs(1'b1);
    wait_hs(1'b0);
    wake_pin[0] = ~wake_pin[0];
    repeat (3) @(negedge clk);
    chk_mode(wcs_pkg::WCS_STOP);
    wait_mode(wcs_pkg::WCS_NORMAL, 20);
    rd_chk(8'h14, 8'h01);
    // forced wake-up periods alongside sense on both outputs
    u_mcu.write_reg(8'h12, 8'hff);
    for (int i = 0; i < 12; i++) begin
      u_mcu.write_reg(8'h13, tim[i]);
      go(wcs_pkg::WCS_STOP);
      wait_mode(wcs_pkg::WCS_NORMAL, cyc[i] * TPM / TPM + 20);
      check((n >= cyc[i] - 2 && n <= cyc[i] + 12) ? 8'h01 : 8'h00,
            8'h01);
      rd_chk(8'h14, 8'h80);
    end
    // input change lands in the very cycle of a forced wake-up
    u_mcu.write_reg(8'h12, 8'h3f);
    u_mcu.write_reg(8'h13, 8'h10);
    go(wcs_pkg::WCS_STOP);
    repeat (7) @(negedge clk);
    wake_pin[1] = ~wake_pin[1];
    wait_mode(wcs_pkg::WCS_NORMAL, 8);
    rd_chk(8'h14, 8'h80);
    give_verdict();
  end
endmodule : wcs_wake_control_tb
